// >>> logic/flash_array.sv
module flash_array import ssp_pkg::*; #(
   parameter int MAIN_BYTES = 16384,
   parameter int EE_BYTES = 2048
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // command and read port
   array_if.mem aif
);
   typedef struct packed {
      logic busy;
      logic bank;
      logic [13:0] base;
      logic [9:0] cnt;
      logic done;
   } arr_t;

   arr_t a_reg;
   arr_t a_next;
   logic [7:0] main_mem [MAIN_BYTES];
   logic [7:0] ee_mem [EE_BYTES];
   logic [7:0] rd_reg;
   logic we;
   logic wbank;
   logic [13:0] waddr;
   logic [7:0] wdata;

   assign aif.done = a_reg.done;
   assign aif.rd_data = rd_reg;

   // erase walks the sector one byte per cycle, program is one write
   always_comb
   begin
      a_next = a_reg;
      a_next.done = 1'b0;
      we = 1'b0;
      wbank = aif.bank;
      waddr = aif.addr;
      wdata = aif.data;
      if (a_reg.busy)
      begin
         we = 1'b1;
         wbank = a_reg.bank;
         waddr = a_reg.base | {4'h0, a_reg.cnt};
         wdata = ERASED;
         a_next.cnt = a_reg.cnt + 10'h001;
         if (a_reg.cnt == (a_reg.bank ? EE_LAST : MAIN_LAST))
         begin
            a_next.busy = 1'b0;
            a_next.done = 1'b1;
         end
      end
      else if (aif.start && aif.erase)
      begin
         a_next.busy = 1'b1;
         a_next.bank = aif.bank;
         a_next.cnt = '0;
         a_next.base = aif.bank ? {aif.addr[13:8], 8'h00} : {aif.addr[13:10], 10'h000};
      end
      else if (aif.start)
      begin
         we = 1'b1;
         a_next.done = 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         a_reg <= '0;
      else
         a_reg <= a_next;
   end

   // storage; a program step can only clear bits, as flash does
   always_ff @(posedge core_clk)
   begin
      if (we && wbank)
         ee_mem[waddr[10:0]] <= a_reg.busy ? wdata : ee_mem[waddr[10:0]] & wdata;
      if (we && !wbank)
         main_mem[waddr] <= a_reg.busy ? wdata : main_mem[waddr] & wdata;
      if (aif.rd_en)
         rd_reg <= aif.rd_bank ? ee_mem[aif.rd_addr[10:0]] : main_mem[aif.rd_addr];
   end
endmodule

// >>> logic/flash_ssp_ctrl.sv
// Summary of operation
// - type register E6 means sector erase, 6E means byte program.
// - first key low nibble must be 5, else operation abandoned.
// - second key low nibble must be A, else operation abandoned.
// - third key low nibble must be 9, else operation abandoned.
// - fourth key low nibble must be 6, else operation abandoned.
// - program data register supplies the byte written.
// - select bit picks main flash or second array for reads and writes.
// - byte write holds cpu idle, execution resumes afterwards.
// - erase holds cpu idle until the sector is erased.
// - fixed per-chip random byte, not erasable, readable.
// - code read of 0A7F with select set returns the random byte.
// - main flash: page bits 7-2 sector, bits 1-0 offset high part.
// - offset register gives low eight offset bits.
// - second array: 256-byte sectors picked by page bits 2-0.
// - erase of main sector 15 is refused.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
module flash_ssp_ctrl import ssp_pkg::*; #(
   parameter int ERASE_CYCLES_P = ERASE_CYCLES,
   parameter int PROG_CYCLES_P = PROG_CYCLES,
   parameter logic [7:0] RANDOM_VALUE = 8'h5a
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // avalon-mm slave
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // code read port
   input wire logic code_rd,
   input wire logic [15:0] code_addr,
   output logic [7:0] code_data,
   output logic code_valid,
   // cpu hold
   output logic cpu_idle
);
   typedef struct packed {
      ctrl_state_t state;
      logic bank;
      logic [7:0] op_type;
      logic [3:0] key1;
      logic [3:0] key2;
      logic [3:0] key3;
      logic [3:0] key4;
      logic [7:0] page;
      logic [7:0] offset;
      logic [7:0] data;
      logic [31:0] readdata;
      logic waitrequest;
      logic [31:0] timer;
      logic arr_done;
      logic start;
      logic erase;
      logic refused;
      logic aborted;
      logic done;
      logic rd_pend;
      logic rd_rnd;
      logic [7:0] code_data;
      logic code_valid;
      logic cpu_idle;
   } ctrl_t;

   localparam ctrl_t CTRL_RESET = '{state: CTRL_IDLE, waitrequest: 1'b1, default: '0};

   ctrl_t r_reg;
   ctrl_t r_next;
   key_if kif ();
   array_if aif ();
   logic [7:0] idx;
   logic req;
   logic acc;
   logic wr;
   logic [7:0] wb;
   logic rnd_hit;

   // bus decode; an access completes on the edge that sees waitrequest low
   assign idx = reg_index(avs_address);
   assign req = avs_read | avs_write;
   assign acc = req && !r_reg.waitrequest;
   assign wr = avs_write && acc && avs_byteenable[0];
   assign wb = avs_writedata[7:0];

   // key writes go to the sequence checker as one-cycle strobes
   assign kif.type_wr = wr && idx == IDX_TYPE;
   assign kif.key_wr = {wr && idx == IDX_KEY4, wr && idx == IDX_KEY3,
      wr && idx == IDX_KEY2, wr && idx == IDX_KEY1};
   assign kif.nibble = wb[3:0];

   key_sequencer u_keys (
      .core_clk(core_clk),
      .srst(srst),
      .kif(kif)
   );

   // array select for writes and code reads
   assign aif.bank = r_reg.bank;
   assign aif.rd_bank = r_reg.bank;
   assign aif.addr = r_reg.bank ? {3'h0, r_reg.page[2:0], r_reg.offset}
      : {r_reg.page[5:0], r_reg.offset};
   assign aif.data = r_reg.data;
   assign aif.start = r_reg.start;
   assign aif.erase = r_reg.erase;
   assign aif.rd_addr = code_addr[13:0];

   // random byte sits at a fixed code address of the second array
   assign rnd_hit = r_reg.bank && code_addr == RANDOM_ADDR;
   assign aif.rd_en = code_rd && r_reg.state == CTRL_IDLE && !rnd_hit;

   flash_array u_array (
      .core_clk(core_clk),
      .srst(srst),
      .aif(aif)
   );

   // outputs straight from flip-flops
   assign avs_readdata = r_reg.readdata;
   assign avs_waitrequest = r_reg.waitrequest;
   assign code_data = r_reg.code_data;
   assign code_valid = r_reg.code_valid;
   assign cpu_idle = r_reg.cpu_idle;

   // next-state of the whole controller
   always_comb
   begin
      logic legal;
      logic [5:0] sector;
      legal = 1'b0;
      sector = r_reg.page[7:2];
      r_next = r_reg;
      r_next.waitrequest = 1'b1;
      r_next.start = 1'b0;
      r_next.code_valid = 1'b0;
      r_next.rd_pend = 1'b0;

      // grant one cycle of waitrequest low; none while busy or starting,
      // so the cpu is stalled for the whole operation
      if (req && r_reg.waitrequest && r_reg.state == CTRL_IDLE && !kif.go && !r_reg.start)
      begin
         r_next.waitrequest = 1'b0;
         case (idx)
            IDX_BANK: r_next.readdata = {31'h0, r_reg.bank};
            IDX_TYPE: r_next.readdata = {24'h0, r_reg.op_type};
            IDX_KEY1: r_next.readdata = {28'h0, r_reg.key1};
            IDX_KEY2: r_next.readdata = {28'h0, r_reg.key2};
            IDX_KEY3: r_next.readdata = {28'h0, r_reg.key3};
            IDX_KEY4: r_next.readdata = {28'h0, r_reg.key4};
            IDX_PAGE: r_next.readdata = {24'h0, r_reg.page};
            IDX_OFFSET: r_next.readdata = {24'h0, r_reg.offset};
            IDX_DATA: r_next.readdata = {24'h0, r_reg.data};
            IDX_STATUS: r_next.readdata = {28'h0, r_reg.done, r_reg.aborted,
               r_reg.refused, r_reg.state == CTRL_BUSY};
            default: r_next.readdata = 32'h0;
         endcase
      end

      // register writes; only the low byte lane is implemented
      if (wr)
      begin
         case (idx)
            IDX_BANK: r_next.bank = wb[0];
            IDX_TYPE:
            begin
               r_next.op_type = wb;
               // a new sequence clears the last result
               r_next.refused = 1'b0;
               r_next.aborted = 1'b0;
               r_next.done = 1'b0;
            end
            IDX_KEY1: r_next.key1 = wb[3:0];
            IDX_KEY2: r_next.key2 = wb[3:0];
            IDX_KEY3: r_next.key3 = wb[3:0];
            IDX_KEY4: r_next.key4 = wb[3:0];
            IDX_PAGE: r_next.page = wb;
            IDX_OFFSET: r_next.offset = wb;
            IDX_DATA: r_next.data = wb;
            default: r_next.bank = r_reg.bank;
         endcase
      end

      // wrong key or order leaves memory untouched
      if (kif.abort)
         r_next.aborted = 1'b1;

      case (r_reg.state)
         CTRL_IDLE:
         begin
            if (kif.go)
            begin
               if (r_reg.op_type == OP_ERASE)
                  legal = r_reg.bank || (sector < MAIN_SECTORS && sector != LOCKED_SECTOR);
               else if (r_reg.op_type == OP_PROGRAM)
                  legal = r_reg.bank || sector < MAIN_SECTORS;
               // last main sector cannot be erased from software
               if (legal)
               begin
                  // hold the cpu idle for the operation
                  r_next.state = CTRL_BUSY;
                  r_next.cpu_idle = 1'b1;
                  r_next.start = 1'b1;
                  r_next.erase = r_reg.op_type == OP_ERASE;
                  r_next.arr_done = 1'b0;
                  r_next.timer = (r_reg.op_type == OP_ERASE) ? ERASE_CYCLES_P : PROG_CYCLES_P;
               end
               else
                  r_next.refused = 1'b1;
            end
         end
         CTRL_BUSY:
         begin
            // the array may finish first; the timer sets the least hold
            if (aif.done)
               r_next.arr_done = 1'b1;
            if (r_reg.timer > 32'h1)
               r_next.timer = r_reg.timer - 32'h1;
            else if (r_reg.arr_done || aif.done)
            begin
               r_next.timer = 32'h0;
               r_next.state = CTRL_IDLE;
               r_next.cpu_idle = 1'b0;
               r_next.done = 1'b1;
            end
            else
               r_next.timer = 32'h0;
         end
         default:
         begin
            r_next.state = CTRL_IDLE;
            r_next.cpu_idle = 1'b0;
         end
      endcase

      // code reads take two cycles; refused while an operation runs
      if (code_rd && r_reg.state == CTRL_IDLE)
      begin
         r_next.rd_pend = 1'b1;
         r_next.rd_rnd = rnd_hit;
      end
      if (r_reg.rd_pend)
      begin
         // random byte is a constant, never touched by erase
         r_next.code_data = r_reg.rd_rnd ? RANDOM_VALUE : aif.rd_data;
         r_next.code_valid = 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         r_reg <= CTRL_RESET;
      else
         r_reg <= r_next;
   end

   // reset leaves every register at zero and the bus stalled
   reset_clear_a: assert property (@(posedge core_clk)
      srst |=> (r_reg.bank == 1'b0 && r_reg.key1 == 4'h0 && r_reg.page == 8'h00
      && r_reg.op_type == 8'h00 && !cpu_idle && avs_waitrequest))
      else $error("register not cleared by reset");

   // an erase of the second array is always legal and starts at once
   erase_start_a: assert property (@(posedge core_clk) disable iff (srst)
      (kif.go && r_reg.state == CTRL_IDLE && r_reg.op_type == OP_ERASE && r_reg.bank)
      |=> (aif.start && aif.erase && cpu_idle))
      else $error("legal erase did not start");

   // codes other than erase and program never reach the array
   no_bad_type_a: assert property (@(posedge core_clk) disable iff (srst)
      (kif.go && r_reg.op_type != OP_ERASE && r_reg.op_type != OP_PROGRAM)
      |=> (!aif.start && r_reg.refused))
      else $error("unknown operation code was started");

   // the last main sector must never be erased from software
   locked_sector_a: assert property (@(posedge core_clk) disable iff (srst)
      (aif.start && aif.erase) |-> (aif.bank || aif.addr[13:10] != LOCKED_SECTOR[3:0]))
      else $error("erase of locked sector started");

   // a program start follows a program sequence and carries the data byte
   program_byte_a: assert property (@(posedge core_clk) disable iff (srst)
      (aif.start && !aif.erase) |-> ($past(kif.go && r_reg.op_type == OP_PROGRAM)
      && aif.data == r_reg.data && aif.bank == r_reg.bank))
      else $error("program used wrong byte or address");

   // the cpu stays stalled for the first cycles of any operation
   idle_hold_a: assert property (@(posedge core_clk) disable iff (srst)
      aif.start |=> (cpu_idle && avs_waitrequest) [*8])
      else $error("cpu released too early");

   // a refused erase of the locked sector neither starts nor stalls the cpu
   refused_no_hold_a: assert property (@(posedge core_clk) disable iff (srst)
      (kif.go && r_reg.state == CTRL_IDLE && !r_reg.bank && r_reg.op_type == OP_ERASE
      && r_reg.page[7:2] == LOCKED_SECTOR) |=> (!aif.start && !cpu_idle && r_reg.refused))
      else $error("locked sector erase not refused");

   // an aborted sequence leaves the array alone
   abort_no_start_a: assert property (@(posedge core_clk) disable iff (srst)
      kif.abort |=> (!aif.start && !cpu_idle && r_reg.aborted))
      else $error("aborted sequence started an operation");

   // the cpu is held until the array reports the operation finished
   erase_hold_a: assert property (@(posedge core_clk) disable iff (srst)
      (r_reg.state == CTRL_BUSY && !r_reg.arr_done && !aif.done) |=> cpu_idle)
      else $error("cpu released before the array finished");

   // the cpu is let go only together with the done flag
   release_done_a: assert property (@(posedge core_clk) disable iff (srst)
      $fell(cpu_idle) |-> r_reg.done)
      else $error("cpu released without done");

   // the random byte comes back two cycles after the code read
   random_read_a: assert property (@(posedge core_clk) disable iff (srst)
      (code_rd && r_reg.state == CTRL_IDLE && r_reg.bank && code_addr == RANDOM_ADDR)
      |-> ##2 (code_valid && code_data == RANDOM_VALUE))
      else $error("random byte not returned");

   // every code read taken while idle is answered two cycles later
   code_answer_a: assert property (@(posedge core_clk) disable iff (srst)
      (code_rd && r_reg.state == CTRL_IDLE) |-> ##2 code_valid)
      else $error("code read not answered");

   // an idle controller answers a bus request within two cycles
   bus_answer_a: assert property (@(posedge core_clk) disable iff (srst)
      (req && r_reg.state == CTRL_IDLE && !kif.go && !r_reg.start && !aif.start)
      |-> ##[0:2] !avs_waitrequest)
      else $error("idle bus request not answered");
endmodule

// >>> logic/key_sequencer.sv
module key_sequencer import ssp_pkg::*; (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // key writes
   key_if.seq kif
);
   typedef struct packed {
      key_state_t st;
      logic go;
      logic abort;
   } seq_t;

   seq_t s_reg;
   seq_t s_next;

   assign kif.go = s_reg.go;
   assign kif.abort = s_reg.abort;

   // expected key and register for each armed state
   always_comb
   begin
      logic [3:0] exp;
      logic [3:0] step;
      key_state_t nxt;
      exp = KEY1;
      step = 4'h1;
      nxt = KEY_WAIT2;
      s_next = s_reg;
      s_next.go = 1'b0;
      s_next.abort = 1'b0;
      case (s_reg.st)
         KEY_WAIT1:
         begin
            exp = KEY1;
            step = 4'h1;
            nxt = KEY_WAIT2;
         end
         KEY_WAIT2:
         begin
            exp = KEY2;
            step = 4'h2;
            nxt = KEY_WAIT3;
         end
         KEY_WAIT3:
         begin
            exp = KEY3;
            step = 4'h4;
            nxt = KEY_WAIT4;
         end
         KEY_WAIT4:
         begin
            exp = KEY4;
            step = 4'h8;
            nxt = KEY_IDLE;
         end
         default:
         begin
            exp = KEY1;
            step = 4'h0;
            nxt = KEY_IDLE;
         end
      endcase
      // writing the type register always rearms the sequence
      if (kif.type_wr)
         s_next.st = KEY_WAIT1;
      else if (|kif.key_wr && s_reg.st != KEY_IDLE)
      begin
         if (kif.key_wr == step && kif.nibble == exp)
         begin
            s_next.st = nxt;
            s_next.go = (s_reg.st == KEY_WAIT4);
         end
         else
         begin
            s_next.st = KEY_IDLE;
            s_next.abort = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         s_reg <= '{st: KEY_IDLE, default: '0};
      else
         s_reg <= s_next;
   end

   wrong_key_abort_a: assert property (@(posedge core_clk) disable iff (srst)
      (s_reg.st == KEY_WAIT1 && kif.key_wr == 4'h1 && kif.nibble != KEY1 && !kif.type_wr)
      |=> (kif.abort && s_reg.st == KEY_IDLE && !kif.go))
      else $error("wrong first key did not abort");
   go_after_fourth_a: assert property (@(posedge core_clk) disable iff (srst)
      kif.go |-> $past(s_reg.st == KEY_WAIT4 && kif.key_wr == 4'h8 && kif.nibble == KEY4))
      else $error("go without correct fourth key");
endmodule

// >>> logic/ssp_if.sv
// flow key writes towards the sequence checker
interface key_if;
   logic type_wr;
   logic [3:0] key_wr;
   logic [3:0] nibble;
   logic go;
   logic abort;
   modport ctrl (output type_wr, key_wr, nibble, input go, abort);
   modport seq (input type_wr, key_wr, nibble, output go, abort);
endinterface

// commands and code reads towards the storage arrays
interface array_if;
   logic start;
   logic erase;
   logic bank;
   logic [13:0] addr;
   logic [7:0] data;
   logic done;
   logic rd_en;
   logic rd_bank;
   logic [13:0] rd_addr;
   logic [7:0] rd_data;
   modport ctrl (output start, erase, bank, addr, data, rd_en, rd_bank, rd_addr,
      input done, rd_data);
   modport mem (input start, erase, bank, addr, data, rd_en, rd_bank, rd_addr,
      output done, rd_data);
endinterface

// >>> logic/ssp_pkg.sv
package ssp_pkg;
   // timing, clock is 10 MHz
   localparam int CLK_MHZ = 10;
   localparam int PROG_TIME_US = 30;
   localparam int ERASE_TIME_US = 10000;
   localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
   localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
   // register indexes, byte address is four times the index
   localparam logic [7:0] IDX_BANK = 8'ha7;
   localparam logic [7:0] IDX_TYPE = 8'hf2;
   localparam logic [7:0] IDX_KEY1 = 8'hf3;
   localparam logic [7:0] IDX_KEY2 = 8'hf4;
   localparam logic [7:0] IDX_KEY3 = 8'hf5;
   localparam logic [7:0] IDX_KEY4 = 8'hf6;
   localparam logic [7:0] IDX_PAGE = 8'hf7;
   localparam logic [7:0] IDX_OFFSET = 8'hfb;
   localparam logic [7:0] IDX_DATA = 8'hfc;
   localparam logic [7:0] IDX_STATUS = 8'h80;
   // operation codes and flow keys
   localparam logic [7:0] OP_ERASE = 8'he6;
   localparam logic [7:0] OP_PROGRAM = 8'h6e;
   localparam logic [3:0] KEY1 = 4'h5;
   localparam logic [3:0] KEY2 = 4'ha;
   localparam logic [3:0] KEY3 = 4'h9;
   localparam logic [3:0] KEY4 = 4'h6;
   // arrays and sectors
   localparam logic [15:0] RANDOM_ADDR = 16'h0a7f;
   localparam logic [5:0] MAIN_SECTORS = 6'h10;
   localparam logic [5:0] LOCKED_SECTOR = 6'h0f;
   localparam logic [9:0] MAIN_LAST = 10'h3ff;
   localparam logic [9:0] EE_LAST = 10'h0ff;
   localparam logic [7:0] ERASED = 8'hff;
   // status bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_REFUSED = 1;
   localparam int ST_ABORTED = 2;
   localparam int ST_DONE = 3;

   typedef enum logic [1:0] {
      CTRL_IDLE = 2'b01,
      CTRL_BUSY = 2'b10
   } ctrl_state_t;

   typedef enum logic [4:0] {
      KEY_IDLE = 5'b00001,
      KEY_WAIT1 = 5'b00010,
      KEY_WAIT2 = 5'b00100,
      KEY_WAIT3 = 5'b01000,
      KEY_WAIT4 = 5'b10000
   } key_state_t;

   function automatic logic [7:0] reg_index(input logic [9:0] a);
      return a[9:2];
   endfunction
endpackage

// >>> sim/test_flash_self_program_sequencer.sv
module test_flash_self_program_sequencer import ssp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   // bus and code read stimulus
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [9:0] avs_address = 10'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic code_rd = 1'b0;
   logic [15:0] code_addr = 16'h0;
   logic [7:0] code_data;
   logic code_valid;
   logic cpu_idle;
   logic [31:0] exp_rd[$];
   logic [7:0] exp_code[$];
   int n_errors = 0;
   int samples_checked = 0;
   logic [7:0] d0;
   logic [7:0] d1;
   logic [7:0] rst_idx [7] = '{IDX_BANK, IDX_TYPE, IDX_KEY1, IDX_KEY4, IDX_PAGE,
      IDX_OFFSET, IDX_DATA};
   // short counts keep the erase and program waits small
   flash_ssp_ctrl #(.ERASE_CYCLES_P(20), .PROG_CYCLES_P(12), .RANDOM_VALUE(8'h5a)) dut (
      .core_clk(core_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .code_rd(code_rd),
      .code_addr(code_addr), .code_data(code_data), .code_valid(code_valid),
      .cpu_idle(cpu_idle));
   always #50 core_clk = ~core_clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("errors %0d, comparisons %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one avalon transfer, held until waitrequest is seen low at a rising edge
   task automatic bus_xfer(input logic rd, input logic [7:0] idx, input logic [7:0] d,
      input logic [3:0] be);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address <= {idx, 2'b00};
      avs_read <= rd;
      avs_write <= ~rd;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 5000);
      if (n >= 5000)
         chk(32'hdead, 32'h0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus_xfer(1'b0, idx, d, 4'h1);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] e);
      exp_rd.push_back(e);
      bus_xfer(1'b1, idx, 8'h00, 4'hf);
   endtask
   task automatic crd(input logic [15:0] a, input logic [7:0] e);
      exp_code.push_back(e);
      @(posedge core_clk);
      code_rd <= 1'b1;
      code_addr <= a;
      @(posedge core_clk);
      code_rd <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask
   // type write, four key writes, then watch the cpu hold and the status
   task automatic run(input logic [7:0] op, input logic [15:0] keys, input logic [7:0] st);
      logic seen;
      seen = 1'b0;
      wr(IDX_TYPE, op);
      for (int i = 0; i < 4; i++)
         wr(IDX_KEY1 + 8'(i), {4'h0, keys[15 - 4 * i -: 4]});
      repeat (8)
      begin
         @(negedge core_clk);
         seen = seen | (cpu_idle === 1'b1);
      end
      chk(32'(seen), 32'(st == 8'h08));
      rd(IDX_STATUS, {24'h0, st});
   endtask
   // results are matched against the oldest note when they appear
   always @(posedge core_clk)
   begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
         chk(avs_readdata, exp_rd.size() ? exp_rd.pop_front() : 32'hbad);
      if (code_valid === 1'b1)
         chk({24'h0, code_data}, exp_code.size() ? {24'h0, exp_code.pop_front()} : 32'hbad);
   end
   // watchdog sized well above the longest expected run
   initial
   begin
      repeat (60000) @(posedge core_clk);
      n_errors++;
      final_report();
   end
   initial
   begin
      void'($urandom(32'hcaf53487));
      d0 = 8'($urandom() % 254) + 8'h01;
      d1 = 8'($urandom() % 254) + 8'h01;
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      // reset values, then an unmapped place
      foreach (rst_idx[i])
         rd(rst_idx[i], 32'h0);
      wr(8'h10, 8'hff);
      rd(8'h10, 32'h0);
      // key registers keep only the low nibble, bank only bit 0
      wr(IDX_KEY2, 8'hfa);
      rd(IDX_KEY2, 32'h0a);
      wr(IDX_BANK, 8'hff);
      rd(IDX_BANK, 32'h01);
      wr(IDX_DATA, d0);
      bus_xfer(1'b0, IDX_DATA, ~d0, 4'h0);
      rd(IDX_DATA, {24'h0, d0});
      // erase main sector 0, program one byte with offset high bits
      wr(IDX_BANK, 8'h00);
      wr(IDX_PAGE, 8'h00);
      run(OP_ERASE, {KEY1, KEY2, KEY3, KEY4}, 8'h08);
      crd(16'h0125, ERASED);
      wr(IDX_PAGE, 8'h01);
      wr(IDX_OFFSET, 8'h25);
      run(OP_PROGRAM, {KEY1, KEY2, KEY3, KEY4}, 8'h08);
      crd(16'h0125, d0);
      // one wrong key in each position: aborted, byte untouched
      wr(IDX_DATA, 8'h00);
      for (int k = 0; k < 4; k++)
         run(OP_PROGRAM, {KEY1, KEY2, KEY3, KEY4} ^ (16'h1000 >> (4 * k)), 8'h04);
      crd(16'h0125, d0);
      // an illegal code and the locked last sector are refused
      run(8'h55, {KEY1, KEY2, KEY3, KEY4}, 8'h02);
      wr(IDX_PAGE, 8'h3c);
      run(OP_ERASE, {KEY1, KEY2, KEY3, KEY4}, 8'h02);
      // second array: reserved page bits ignored, then the random byte
      wr(IDX_BANK, 8'h01);
      wr(IDX_PAGE, 8'h01);
      run(OP_ERASE, {KEY1, KEY2, KEY3, KEY4}, 8'h08);
      wr(IDX_PAGE, 8'hf9);
      wr(IDX_OFFSET, 8'h10);
      wr(IDX_DATA, d1);
      run(OP_PROGRAM, {KEY1, KEY2, KEY3, KEY4}, 8'h08);
      crd(16'h0110, d1);
      crd(RANDOM_ADDR, 8'h5a);
      wr(IDX_BANK, 8'h00);
      wr(IDX_PAGE, 8'h00);
      crd(16'h0125, d0);
      // a second reset clears the registers again
      @(posedge core_clk);
      srst <= 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      rd(IDX_DATA, 32'h0);
      rd(IDX_KEY2, 32'h0);
      rd(IDX_STATUS, 32'h0);
      repeat (4) @(posedge core_clk);
      final_report();
   end
endmodule
